//--- hdl/tmr_evt_pkg.sv
// Constants, register map and state codes for the overflow and event-reset timer.
package tmr_evt_pkg;
	// Register indices on the plain register port.
	localparam logic [3:0] ADDR_TIMER_CTRL = 4'h0;
	localparam logic [3:0] ADDR_OSC_CTRL = 4'h1;
	localparam logic [3:0] ADDR_TIMER_CLK_CTRL = 4'h2;
	localparam logic [3:0] ADDR_COUNT_LOW = 4'h3;
	localparam logic [3:0] ADDR_COUNT_HIGH = 4'h4;
	localparam logic [3:0] ADDR_PERIPH_FLAG = 4'h5;
	localparam logic [3:0] ADDR_PERIPH_ENABLE = 4'h6;
	localparam logic [3:0] ADDR_PORT_DIRECTION = 4'h7;
	localparam logic [3:0] ADDR_PORT_DATA = 4'h8;
	localparam logic [3:0] ADDR_CMP_A_MODE = 4'h9;
	localparam logic [3:0] ADDR_CMP_A_LOW = 4'ha;
	localparam logic [3:0] ADDR_CMP_A_HIGH = 4'hb;
	localparam logic [3:0] ADDR_CMP_B_MODE = 4'hc;
	localparam logic [3:0] ADDR_CMP_B_LOW = 4'hd;
	localparam logic [3:0] ADDR_CMP_B_HIGH = 4'he;
	// Field positions.
	localparam int BIT_TIMER_ON = 0;
	localparam int BIT_OSC_ENABLE = 3;
	localparam int BIT_IDLE_ON_SLEEP = 7;
	localparam int BIT_SEC_ACTIVE = 4;
	localparam int BIT_OVERFLOW = 0;
	localparam int BIT_OVERFLOW_EN = 0;
	// Field values and reset values.
	localparam logic [1:0] SCS_SECONDARY = 2'h1;
	localparam logic [3:0] MODE_SPECIAL_EVENT = 4'hb;
	localparam logic [1:0] ASSIGN_BOTH = 2'h0;
	localparam logic [1:0] ASSIGN_A_ONLY = 2'h1;
	localparam logic [7:0] RESET_BYTE = 8'h00;
	localparam logic [15:0] COUNT_MAX = 16'hffff;
	localparam logic [15:0] COUNT_ZERO = 16'h0000;
	localparam logic [15:0] CMP_RESET = 16'hffff;
	localparam logic [1:0] PORT_DIR_RESET = 2'h3;
	localparam int NUM_UNITS = 2;
	// System clock power states.
	typedef enum logic [3:0] {
		primary_run_state = 4'b0001,
		secondary_run_state = 4'b0010,
		secondary_idle_state = 4'b0100,
		sleep_state = 4'b1000
	} power_state_type;
endpackage

//--- hdl/cmp_link_if.sv
// Connection between the timer and one compare unit.
`timescale 1ns/100ps
interface cmp_link_if;
	logic [15:0] count;
	logic [15:0] value;
	logic [3:0] mode;
	logic assigned;
	logic trigger;
	modport timer (output count, output value, output mode, output assigned, input trigger);
	modport unit (input count, input value, input mode, input assigned, output trigger);
endinterface

//--- hdl/cmp_event_unit.sv
// Compare unit match detection producing the special event trigger.
`timescale 1ns/100ps
module cmp_event_unit
	import tmr_evt_pkg::*;
(
	input wire logic clk,
	input wire logic resetn,
	cmp_link_if.unit link
);
	logic matched;
	logic armed;

	// A match only counts for a unit tied to this timer in event mode.
	assign matched = link.assigned && (link.mode == MODE_SPECIAL_EVENT) &&
		(link.count == link.value);

	// One trigger per match: rearmed once the count leaves the value.
	always_ff @(posedge clk) begin
		if (!resetn) begin
			armed <= 1'b1;
		end else begin
			armed <= !matched;
		end
	end

	assign link.trigger = matched && armed;
endmodule // cmp_event_unit

//--- hdl/tmr_evt_core.sv
// Overflow flag, event reset, secondary oscillator control and clock state.
//
// Overview of operation
// - Oscillator powered only while enable bit set.
// - Oscillator keeps running in every power state.
// - Select code 01 enters secondary run.
// - Sleep with idle bit clear enters secondary idle.
// - Status flag shows secondary clock in use.
// - On failure flag shows the replacement source.
// - Count runs 0000h to FFFFh then wraps.
// - Wrap sets the latched overflow flag.
// - Interrupt only when overflow enable is set.
// - Compare mode 1011 match resets the count.
// - Unit b trigger starts enabled conversion.
// - Compare value acts as the timer period.
// - Count write beats a coincident trigger.
// - Enabled oscillator forces its pins to zero inputs.
`timescale 1ns/100ps
module tmr_evt_core
	import tmr_evt_pkg::*;
(
	input wire logic clk,
	input wire logic resetn,
	input wire logic [3:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [7:0] rdata,
	input wire logic count_tick,
	input wire logic sleep_req,
	input wire logic wake_req,
	input wire logic clock_monitor_on,
	input wire logic sec_osc_fail,
	input wire logic adc_enabled,
	input wire logic sec_osc_in_pin,
	input wire logic sec_osc_out_pin,
	output logic sec_osc_power,
	output logic sec_clock_active,
	output logic [3:0] power_state,
	output logic irq,
	output logic adc_start,
	output logic [1:0] port_out,
	output logic [1:0] port_oe
);
	logic [7:0] timer_control_reg;
	logic [7:0] osc_control_reg;
	logic [1:0] unit_assign;
	logic [15:0] count;
	logic overflow_flag;
	logic overflow_irq_enable;
	logic [1:0] port_direction_reg;
	logic [1:0] port_latch;
	logic [3:0] cmp_mode [NUM_UNITS];
	logic [15:0] cmp_value [NUM_UNITS];
	logic [NUM_UNITS-1:0] unit_trigger;
	logic [NUM_UNITS-1:0] unit_assigned;
	logic [1:0] pin_meta;
	logic [1:0] pin_sync;
	logic fail_meta;
	logic fail_sync;
	power_state_type state;
	power_state_type next_state;
	logic sec_osc_enable;
	logic sec_fail;
	logic count_write;
	logic event_reset;
	logic wrap;
	logic [7:0] next_rdata;

	assign sec_osc_enable = timer_control_reg[BIT_OSC_ENABLE];
	assign sec_fail = clock_monitor_on && fail_sync;
	assign count_write = wr && (addr == ADDR_COUNT_LOW || addr == ADDR_COUNT_HIGH);
	assign event_reset = |unit_trigger;
	assign wrap = count_tick && timer_control_reg[BIT_TIMER_ON] && (count == COUNT_MAX);

	// Pins and the failure detector come from outside the clock domain.
	always_ff @(posedge clk) begin
		if (!resetn) begin
			pin_meta <= 2'h0;
			pin_sync <= 2'h0;
			fail_meta <= 1'b0;
			fail_sync <= 1'b0;
		end else begin
			pin_meta <= {sec_osc_in_pin, sec_osc_out_pin};
			pin_sync <= pin_meta;
			fail_meta <= sec_osc_fail;
			fail_sync <= fail_meta;
		end
	end

	// Software control registers.
	always_ff @(posedge clk) begin
		if (!resetn) begin
			timer_control_reg <= RESET_BYTE;
			osc_control_reg <= RESET_BYTE;
			unit_assign <= ASSIGN_BOTH;
			overflow_irq_enable <= 1'b0;
			port_direction_reg <= PORT_DIR_RESET;
			port_latch <= 2'h0;
		end else if (wr) begin
			unique case (addr)
				ADDR_TIMER_CTRL: timer_control_reg <= wdata;
				ADDR_OSC_CTRL: osc_control_reg <= wdata;
				ADDR_TIMER_CLK_CTRL: unit_assign <= wdata[1:0];
				ADDR_PERIPH_ENABLE: overflow_irq_enable <= wdata[BIT_OVERFLOW_EN];
				ADDR_PORT_DIRECTION: port_direction_reg <= wdata[1:0];
				ADDR_PORT_DATA: port_latch <= wdata[1:0];
				default: ;
			endcase
		end
	end

	// Compare unit registers, one set per unit.
	always_ff @(posedge clk) begin
		if (!resetn) begin
			for (int i = 0; i < NUM_UNITS; i++) begin
				cmp_mode[i] <= 4'h0;
				cmp_value[i] <= CMP_RESET;
			end
		end else if (wr) begin
			unique case (addr)
				ADDR_CMP_A_MODE: cmp_mode[0] <= wdata[3:0];
				ADDR_CMP_A_LOW: cmp_value[0][7:0] <= wdata;
				ADDR_CMP_A_HIGH: cmp_value[0][15:8] <= wdata;
				ADDR_CMP_B_MODE: cmp_mode[1] <= wdata[3:0];
				ADDR_CMP_B_LOW: cmp_value[1][7:0] <= wdata;
				ADDR_CMP_B_HIGH: cmp_value[1][15:8] <= wdata;
				default: ;
			endcase
		end
	end

	// Which compare units feed this timer.
	assign unit_assigned[0] = (unit_assign == ASSIGN_BOTH) || (unit_assign == ASSIGN_A_ONLY);
	assign unit_assigned[1] = (unit_assign == ASSIGN_BOTH);

	// One compare unit per channel, each watching the live count.
	generate
		for (genvar u = 0; u < NUM_UNITS; u++) begin : g_unit
			cmp_link_if link ();
			assign link.count = count;
			assign link.value = cmp_value[u];
			assign link.mode = cmp_mode[u];
			assign link.assigned = unit_assigned[u];
			assign unit_trigger[u] = link.trigger;
			cmp_event_unit unit (
				.clk(clk),
				.resetn(resetn),
				.link(link.unit)
			);
		end
	endgenerate

	// The count: a write wins, then an event reset, then the tick.
	always_ff @(posedge clk) begin
		if (!resetn) begin
			count <= COUNT_ZERO;
		end else if (count_write) begin
			if (addr == ADDR_COUNT_LOW) begin
				count[7:0] <= wdata;
			end else begin
				count[15:8] <= wdata;
			end
		end else if (event_reset) begin
			count <= COUNT_ZERO;
		end else if (count_tick && timer_control_reg[BIT_TIMER_ON]) begin
			count <= count + 16'h0001;
		end
	end

	// Overflow flag: set by a real wrap or a written 1, and the set beats a clear.
	always_ff @(posedge clk) begin
		if (!resetn) begin
			overflow_flag <= 1'b0;
		end else if (wrap && !count_write && !event_reset) begin
			overflow_flag <= 1'b1;
		end else if (wr && addr == ADDR_PERIPH_FLAG) begin
			overflow_flag <= wdata[BIT_OVERFLOW];
		end
	end

	// Interrupt request and conversion start.
	always_ff @(posedge clk) begin
		if (!resetn) begin
			irq <= 1'b0;
			adc_start <= 1'b0;
		end else begin
			irq <= overflow_flag && overflow_irq_enable;
			adc_start <= unit_trigger[1] && adc_enabled;
		end
	end

	// Power state: secondary clock when selected, primary after a failure in secondary run or idle; sleep ignores it.
	always_comb begin
		next_state = state;
		unique case (state)
			primary_run_state: begin
				if (osc_control_reg[1:0] == SCS_SECONDARY && sec_osc_enable && !sec_fail) begin
					next_state = secondary_run_state;
				end
			end
			secondary_run_state: begin
				if (sec_fail || osc_control_reg[1:0] != SCS_SECONDARY) begin
					next_state = primary_run_state;
				end else if (sleep_req && !osc_control_reg[BIT_IDLE_ON_SLEEP]) begin
					next_state = secondary_idle_state;
				end else if (sleep_req) begin
					next_state = sleep_state;
				end
			end
			secondary_idle_state: begin
				if (sec_fail) begin
					next_state = primary_run_state;
				end else if (wake_req) begin
					next_state = secondary_run_state;
				end
			end
			sleep_state: begin
				if (wake_req) begin
					next_state = secondary_run_state;
				end
			end
			default: next_state = primary_run_state;
		endcase
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			state <= primary_run_state;
		end else begin
			state <= next_state;
		end
	end

	// Oscillator power and clock status follow the enable bit and state.
	always_ff @(posedge clk) begin
		if (!resetn) begin
			sec_osc_power <= 1'b0;
			sec_clock_active <= 1'b0;
			power_state <= primary_run_state;
		end else begin
			sec_osc_power <= next_osc_power(timer_control_reg, wr, addr, wdata);
			sec_clock_active <= next_state inside {secondary_run_state,
				secondary_idle_state};
			power_state <= next_state;
		end
	end

	// The enable bit as it stands after this cycle's write.
	function automatic logic next_osc_power(input logic [7:0] ctrl, input logic w,
		input logic [3:0] a, input logic [7:0] d);
		logic v;
		v = ctrl[BIT_OSC_ENABLE];
		if (w && a == ADDR_TIMER_CTRL) begin
			v = d[BIT_OSC_ENABLE];
		end
		return v;
	endfunction

	// Port pins are released to inputs while the oscillator owns them.
	always_ff @(posedge clk) begin
		if (!resetn) begin
			port_oe <= 2'h0;
			port_out <= 2'h0;
		end else begin
			port_oe <= next_osc_power(timer_control_reg, wr, addr, wdata) ? 2'h0 :
				~port_direction_reg;
			port_out <= port_latch;
		end
	end

	// Read multiplexer; unmapped addresses read as zero.
	always_comb begin
		next_rdata = RESET_BYTE;
		unique case (addr)
			ADDR_TIMER_CTRL: next_rdata = timer_control_reg;
			ADDR_OSC_CTRL: next_rdata = osc_control_reg;
			ADDR_TIMER_CLK_CTRL: next_rdata = {3'h0, sec_clock_active, 2'h0, unit_assign};
			ADDR_COUNT_LOW: next_rdata = count[7:0];
			ADDR_COUNT_HIGH: next_rdata = count[15:8];
			ADDR_PERIPH_FLAG: next_rdata = {7'h00, overflow_flag};
			ADDR_PERIPH_ENABLE: next_rdata = {7'h00, overflow_irq_enable};
			ADDR_PORT_DIRECTION: next_rdata = {6'h00, port_direction_reg};
			ADDR_PORT_DATA: next_rdata = sec_osc_enable ? RESET_BYTE :
				{6'h00, pin_sync};
			ADDR_CMP_A_MODE: next_rdata = {4'h0, cmp_mode[0]};
			ADDR_CMP_A_LOW: next_rdata = cmp_value[0][7:0];
			ADDR_CMP_A_HIGH: next_rdata = cmp_value[0][15:8];
			ADDR_CMP_B_MODE: next_rdata = {4'h0, cmp_mode[1]};
			ADDR_CMP_B_LOW: next_rdata = cmp_value[1][7:0];
			ADDR_CMP_B_HIGH: next_rdata = cmp_value[1][15:8];
			default: next_rdata = RESET_BYTE;
		endcase
	end

	// Read data stand only in the cycle after the strobe.
	always_ff @(posedge clk) begin
		if (!resetn) begin
			rdata <= RESET_BYTE;
		end else begin
			rdata <= rd ? next_rdata : RESET_BYTE;
		end
	end

	// Checks on the guarded behaviour.
	chk_osc_power_follows: assert property (@(posedge clk) disable iff (!resetn)
		(wr && addr == ADDR_TIMER_CTRL)
		|=> sec_osc_power == $past(wdata[BIT_OSC_ENABLE]))
		else $error("oscillator power differs from enable bit");
	chk_osc_in_idle: assert property (@(posedge clk) disable iff (!resetn)
		(state == secondary_idle_state && sec_osc_enable && !(wr && addr == ADDR_TIMER_CTRL))
		|=> sec_osc_power)
		else $error("oscillator stopped in a low power state");
	chk_select_enters_sec: assert property (@(posedge clk) disable iff (!resetn)
		(state == primary_run_state && osc_control_reg[1:0] == SCS_SECONDARY &&
		sec_osc_enable && !sec_fail) |=> state == secondary_run_state)
		else $error("secondary run not entered");
	chk_sleep_to_idle: assert property (@(posedge clk) disable iff (!resetn)
		(state == secondary_run_state && sleep_req && !sec_fail &&
		osc_control_reg[1:0] == SCS_SECONDARY && !osc_control_reg[BIT_IDLE_ON_SLEEP])
		|=> state == secondary_idle_state)
		else $error("secondary idle not entered");
	chk_status_flag: assert property (@(posedge clk) disable iff (!resetn)
		sec_clock_active == (state == secondary_run_state || state == secondary_idle_state))
		else $error("clock status flag wrong");
	chk_fail_leaves_sec: assert property (@(posedge clk) disable iff (!resetn)
		(state != primary_run_state && state != sleep_state && sec_fail)
		|=> !sec_clock_active && state == primary_run_state)
		else $error("failed oscillator still reported");
	chk_wrap_to_zero: assert property (@(posedge clk) disable iff (!resetn)
		(wrap && !count_write && !event_reset) |=> count == COUNT_ZERO ##1
		irq == $past(overflow_irq_enable))
		else $error("count did not wrap to zero");
	chk_wrap_sets_flag: assert property (@(posedge clk) disable iff (!resetn)
		(wrap && !count_write && !event_reset) |=> overflow_flag)
		else $error("overflow flag not set on wrap");
	chk_irq_gated: assert property (@(posedge clk) disable iff (!resetn)
		irq |-> $past(overflow_flag) && $past(overflow_irq_enable))
		else $error("interrupt without enabled flag");
	chk_event_clears: assert property (@(posedge clk) disable iff (!resetn)
		(event_reset && !count_write) |=> count == COUNT_ZERO)
		else $error("event trigger did not reset count");
	chk_adc_start: assert property (@(posedge clk) disable iff (!resetn)
		adc_start |-> $past(unit_trigger[1]) && $past(adc_enabled))
		else $error("conversion started without cause");
	chk_write_wins: assert property (@(posedge clk) disable iff (!resetn)
		(event_reset && wr && addr == ADDR_COUNT_LOW) |=> count[7:0] == $past(wdata))
		else $error("trigger overrode count write");
	chk_no_flag_event: assert property (@(posedge clk) disable iff (!resetn)
		(event_reset && !overflow_flag && !(wr && addr == ADDR_PERIPH_FLAG)) |=> !overflow_flag)
		else $error("event reset set the overflow flag");
	chk_pins_released: assert property (@(posedge clk) disable iff (!resetn)
		sec_osc_power |-> port_oe == 2'h0)
		else $error("oscillator pins driven while enabled");
endmodule // tmr_evt_core

//--- test/far_side_model.sv
// Behavioural model of the crystal pins, the timer clock source and the clock monitor.
`timescale 1ns/100ps
module far_side_model (
	input wire logic clk,
	input wire logic resetn,
	input wire logic tick_run,
	input wire logic fail_cmd,
	input wire logic [1:0] pin_level,
	input wire logic sec_osc_power,
	output logic count_tick,
	output logic sec_osc_fail,
	output logic sec_osc_in_pin,
	output logic sec_osc_out_pin
);
	logic swing;

	// Ticks come from the system clock domain, never from an asynchronous counter.
	always_ff @(posedge clk) begin
		count_tick <= resetn & tick_run;
		sec_osc_fail <= resetn & fail_cmd;
	end

	// A powered crystal swings its pins every cycle; otherwise the board drives them.
	always_ff @(posedge clk) begin
		if (!resetn) begin
			swing <= 1'b0;
		end else begin
			swing <= ~swing;
		end
	end
	// The input pin sits on bit 1 of the port and the amplifier output on bit 0.
	assign sec_osc_in_pin = sec_osc_power ? swing : pin_level[1];
	assign sec_osc_out_pin = sec_osc_power ? ~swing : pin_level[0];
endmodule // far_side_model

//--- test/tb_top.sv
// Self-checking testbench for the overflow and event-reset timer core.
`timescale 1ns/100ps
`define chk(g, e) begin check_count++; if ((g) !== (e)) begin n_mismatch++; $display("unexpected %0t: got %h expected %h", $time, (g), (e)); end end
module tb_top;
	import tmr_evt_pkg::*;
	logic clk = 1'b0;
	logic resetn = 1'b0;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [3:0] addr = 4'h0;
	logic [7:0] wdata = 8'h00;
	logic sleep_req = 1'b0;
	logic wake_req = 1'b0;
	logic clock_monitor_on = 1'b0;
	logic adc_enabled = 1'b0;
	logic tick_run = 1'b0;
	logic fail_cmd = 1'b0;
	logic [1:0] pin_level = 2'h2;
	logic [7:0] rdata;
	logic count_tick, sec_osc_fail, sec_osc_in_pin, sec_osc_out_pin;
	logic sec_osc_power, sec_clock_active, irq, adc_start;
	logic [3:0] power_state;
	logic [1:0] port_out, port_oe;
	int n_mismatch = 0;
	int check_count = 0;
	int n_adc = 0;

	tmr_evt_core dut (.clk(clk), .resetn(resetn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
		.rdata(rdata), .count_tick(count_tick), .sleep_req(sleep_req), .wake_req(wake_req),
		.clock_monitor_on(clock_monitor_on), .sec_osc_fail(sec_osc_fail),
		.adc_enabled(adc_enabled), .sec_osc_in_pin(sec_osc_in_pin),
		.sec_osc_out_pin(sec_osc_out_pin), .sec_osc_power(sec_osc_power),
		.sec_clock_active(sec_clock_active), .power_state(power_state), .irq(irq),
		.adc_start(adc_start), .port_out(port_out), .port_oe(port_oe));

	far_side_model far (.clk(clk), .resetn(resetn), .tick_run(tick_run), .fail_cmd(fail_cmd),
		.pin_level(pin_level), .sec_osc_power(sec_osc_power), .count_tick(count_tick),
		.sec_osc_fail(sec_osc_fail), .sec_osc_in_pin(sec_osc_in_pin),
		.sec_osc_out_pin(sec_osc_out_pin));

	// The system clock, 5 ns period.
	initial begin
		forever #2.5 clk = ~clk;
	end

	// Conversion starts are counted as they happen.
	always @(posedge clk) begin
		if (adc_start === 1'b1) n_adc++;
	end

	// One bus cycle, launched just after a rising edge.
	task automatic bus(input logic w, input logic r, input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		wr <= w;
		rd <= r;
		addr <= a;
		wdata <= d;
	endtask

	task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
		bus(1'b1, 1'b0, a, d);
		bus(1'b0, 1'b0, 4'h0, 8'h00);
		repeat (3) @(posedge clk);
	endtask

	// Read data stand only in the cycle after the strobe, so they are sampled there.
	task automatic rd_chk(input logic [3:0] a, input logic [7:0] e);
		bus(1'b0, 1'b1, a, 8'h00);
		bus(1'b0, 1'b0, 4'h0, 8'h00);
		#1;
		`chk(rdata, e)
	endtask

	task automatic ticks(input int n);
		@(posedge clk);
		tick_run <= 1'b1;
		repeat (n) @(posedge clk);
		tick_run <= 1'b0;
		repeat (4) @(posedge clk);
	endtask

	task automatic power_pulse(input logic s);
		@(posedge clk);
		sleep_req <= s;
		wake_req <= ~s;
		@(posedge clk);
		sleep_req <= 1'b0;
		wake_req <= 1'b0;
		repeat (3) @(posedge clk);
	endtask

	task automatic conclude;
		$display("checks %0d, mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	// Cuts a hang short well after the tests should have ended.
	initial begin
		#40000;
		n_mismatch++;
		conclude();
	end

	// Main sequence.
	initial begin
		repeat (6) @(posedge clk);
		resetn <= 1'b1;
		repeat (4) @(posedge clk);
		`chk(power_state, primary_run_state)
		`chk(port_oe, 2'h0)
		rd_chk(ADDR_PORT_DIRECTION, 8'h03);
		rd_chk(ADDR_PORT_DATA, 8'h02);
		wr_reg(ADDR_PORT_DIRECTION, 8'h00);
		wr_reg(ADDR_PORT_DATA, 8'h03);
		`chk(port_oe, 2'h3)
		`chk(port_out, 2'h3)
		`chk(sec_osc_power, 1'b0)
		wr_reg(ADDR_TIMER_CTRL, 8'h08);
		`chk(sec_osc_power, 1'b1)
		`chk(port_oe, 2'h0)
		rd_chk(ADDR_PORT_DATA, 8'h00);
		// Crystal start-up time before the oscillator is relied on.
		repeat (20) @(posedge clk);
		wr_reg(ADDR_OSC_CTRL, 8'h01);
		`chk(power_state, secondary_run_state)
		`chk(sec_clock_active, 1'b1)
		rd_chk(ADDR_TIMER_CLK_CTRL, 8'h10);
		power_pulse(1'b1);
		`chk(power_state, secondary_idle_state)
		`chk(sec_osc_power, 1'b1)
		power_pulse(1'b0);
		`chk(power_state, secondary_run_state)
		wr_reg(ADDR_OSC_CTRL, 8'h81);
		power_pulse(1'b1);
		`chk(power_state, sleep_state)
		`chk(sec_osc_power, 1'b1)
		power_pulse(1'b0);
		clock_monitor_on <= 1'b1;
		fail_cmd <= 1'b1;
		repeat (5) @(posedge clk);
		`chk(power_state, primary_run_state)
		`chk(sec_clock_active, 1'b0)
		rd_chk(ADDR_TIMER_CLK_CTRL, 8'h00);
		fail_cmd <= 1'b0;
		wr_reg(ADDR_OSC_CTRL, 8'h00);
		// Wrap from the maximum count, with and without the interrupt enable.
		wr_reg(ADDR_TIMER_CTRL, 8'h01);
		`chk(sec_osc_power, 1'b0)
		wr_reg(ADDR_COUNT_LOW, 8'hff);
		wr_reg(ADDR_COUNT_HIGH, 8'hff);
		ticks(1);
		rd_chk(ADDR_COUNT_LOW, 8'h00);
		rd_chk(ADDR_COUNT_HIGH, 8'h00);
		rd_chk(ADDR_PERIPH_FLAG, 8'h01);
		`chk(irq, 1'b0)
		wr_reg(ADDR_PERIPH_ENABLE, 8'h01);
		`chk(irq, 1'b1)
		wr_reg(ADDR_PERIPH_FLAG, 8'h00);
		`chk(irq, 1'b0)
		wr_reg(ADDR_PERIPH_ENABLE, 8'h00);
		// Unit a with period 5 restarts the count every sixth tick.
		wr_reg(ADDR_CMP_A_LOW, 8'h05);
		wr_reg(ADDR_CMP_A_HIGH, 8'h00);
		wr_reg(ADDR_CMP_A_MODE, 8'h0b);
		ticks(13);
		rd_chk(ADDR_COUNT_LOW, 8'h01);
		rd_chk(ADDR_PERIPH_FLAG, 8'h00);
		wr_reg(ADDR_TIMER_CLK_CTRL, 8'h02);
		wr_reg(ADDR_COUNT_LOW, 8'h00);
		ticks(7);
		rd_chk(ADDR_COUNT_LOW, 8'h07);
		wr_reg(ADDR_TIMER_CLK_CTRL, 8'h00);
		wr_reg(ADDR_CMP_A_MODE, 8'h00);
		wr_reg(ADDR_COUNT_LOW, 8'h00);
		// Unit b with period 3 starts conversions only while the converter is on.
		wr_reg(ADDR_CMP_B_LOW, 8'h03);
		wr_reg(ADDR_CMP_B_HIGH, 8'h00);
		wr_reg(ADDR_CMP_B_MODE, 8'h0b);
		adc_enabled <= 1'b1;
		n_adc = 0;
		ticks(8);
		`chk(n_adc, 2)
		rd_chk(ADDR_COUNT_LOW, 8'h00);
		adc_enabled <= 1'b0;
		ticks(8);
		`chk(n_adc, 2)
		// With only unit a tied to the timer, unit b no longer restarts the count.
		wr_reg(ADDR_TIMER_CLK_CTRL, 8'h01);
		ticks(8);
		rd_chk(ADDR_COUNT_LOW, 8'h08);
		wr_reg(ADDR_TIMER_CLK_CTRL, 8'h00);
		// A count write in the trigger's cycle wins over the reset.
		bus(1'b1, 1'b0, ADDR_COUNT_LOW, 8'h03);
		bus(1'b1, 1'b0, ADDR_COUNT_LOW, 8'h09);
		bus(1'b0, 1'b0, 4'h0, 8'h00);
		repeat (3) @(posedge clk);
		rd_chk(ADDR_COUNT_LOW, 8'h09);
		// An unmapped index reads zero and ignores writes.
		wr_reg(4'hf, 8'h5a);
		rd_chk(4'hf, 8'h00);
		conclude();
	end
endmodule // tb_top
